// File: ppg_deadband.sv
// Edge delay for one output: delays rising or falling edges by a cycle count
`timescale 1ns/1ps
module ppg_deadband (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Control
  input wire ppg_pkg::ppg_dt_e_t mode,
  input wire logic [11:0] delay,
  // Data
  input wire logic in_lvl,
  output logic out_lvl
);

  typedef struct packed {
    logic [11:0] cnt;
    logic out;
  } ppg_db_state_t;

  ppg_db_state_t s_q, s_d;
  logic edge_wait;

  assign out_lvl = s_q.out;

  // Positive mode holds back turn-on, negative mode holds back turn-off
  always_comb begin
    unique case (mode)
      ppg_pkg::DT_POS: edge_wait = in_lvl & ~s_q.out;
      ppg_pkg::DT_NEG: edge_wait = ~in_lvl & s_q.out;
      ppg_pkg::DT_OFF, ppg_pkg::DT_RSV: edge_wait = 1'b0;
    endcase
  end

  always_comb begin
    s_d = s_q;
    if (!edge_wait || s_q.cnt >= delay) begin
      s_d.out = in_lvl;
      s_d.cnt = '0;
    end else begin
      s_d.cnt = 12'(s_q.cnt + 12'h001);
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule

// File: ppg_generator.sv
// PWM generator control: registers, duty and trigger logic, output steering
//
// Overview of operation
// - Clearing limit enable drops limit request and flag
// - Trigger enable raises requests; clearing drops flag
// - Own time base uses phase register as period
// - Shared duty select picks master duty value
// - Dead-time mode: positive, negative, off, reserved
// - Limit input restarts own time base when enabled
// - Duty update immediate or at period boundary
// - Phase is shift value, or period ignoring low bits
// - Primary dead time, 12 bits, others read zero
// - Alternate dead time, 12 bits, others read zero
// - Trigger output once every divider plus one events
// - Trigger counting starts after roll count matches start
// - Ownership bits hand pins to generator or GPIO
// - Invert bits make each pin active low
// - Pair mode: complementary, independent, push-pull, reserved
// - Force enables put forced values on pins
// - Active fault drives pins from fault values
// - Active limit drives pins from limit values
// - Forced values wait for period boundary if synced
// - Unused trigger control bits read zero
// - Clearing fault enable drops fault flag
// - Zero trigger compare never produces a trigger
//
// Added by the designer: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module ppg_generator (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic NRST,
  // Avalon-MM slave
  input wire logic [5:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // Protection inputs, active high
  input wire logic FAULT_IN,
  input wire logic LIMIT_IN,
  // GPIO values for pins not owned by the generator
  input wire logic GPIO_HIGH,
  input wire logic GPIO_LOW,
  // Power stage and ADC
  output logic HIGH_SIDE_OUT,
  output logic LOW_SIDE_OUT,
  output logic ADC_TRIGGER,
  // Interrupt requests
  output logic FAULT_IRQ,
  output logic LIMIT_IRQ,
  output logic TRIGGER_IRQ
);

  typedef struct packed {
    logic waitreq;
    logic [15:0] rdata;
    ppg_pkg::ppg_ctrl_t ctrl;
    logic [15:0] duty;
    logic [15:0] act_duty;
    logic [15:0] mduty;
    logic [15:0] pper;
    logic [15:0] tcmp;
    logic [15:0] phase;
    ppg_pkg::ppg_dtreg_t dt;
    ppg_pkg::ppg_dtreg_t altdt;
    ppg_pkg::ppg_trg_t trg;
    ppg_pkg::ppg_io_t io;
    ppg_pkg::ppg_pins_t frc_en;
    ppg_pkg::ppg_pins_t frc_val;
    logic push_sel;
    logic [5:0] roll;
    logic armed;
    logic [2:0] div;
    logic adc_trig;
    logic lim_prev;
    logic flt_prev;
    logic out_h;
    logic out_l;
  } ppg_gen_state_t;

  ppg_gen_state_t s_q, s_d;

  logic req, wr_acc;
  logic [15:0] rd_val, wval;
  logic [15:0] prim_cnt, gen_cnt, gen_period, gen_load_val, sel_duty;
  logic prim_wrap, gen_wrap, gen_load, restart;
  logic raw, gh, gl, db_h, db_l, pin_h, pin_l, trig_evt;

  // ***************************************************************
  // Bus slave: one wait cycle, then the access completes
  // ***************************************************************
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] wd, input logic [1:0] be);
    logic [15:0] r;
    r = old;
    if (be[0]) begin
      r[7:0] = wd[7:0];
    end
    if (be[1]) begin
      r[15:8] = wd[15:8];
    end
    return r;
  endfunction

  assign req = AVS_READ | AVS_WRITE;
  assign wr_acc = AVS_WRITE & ~s_q.waitreq;
  assign wval = merge(rd_val, AVS_WRITEDATA[15:0], AVS_BYTEENABLE[1:0]);

  // Unmapped addresses read zero; reserved bits are never stored
  always_comb begin
    case (AVS_ADDRESS)
      ppg_pkg::OFS_CTRL: rd_val = s_q.ctrl;
      ppg_pkg::OFS_DUTY: rd_val = s_q.duty;
      ppg_pkg::OFS_PHASE: rd_val = s_q.phase;
      ppg_pkg::OFS_DT: rd_val = s_q.dt;
      ppg_pkg::OFS_ALTDT: rd_val = s_q.altdt;
      ppg_pkg::OFS_TRG: rd_val = s_q.trg;
      ppg_pkg::OFS_IO: rd_val = s_q.io;
      ppg_pkg::OFS_MDUTY: rd_val = s_q.mduty;
      ppg_pkg::OFS_PPER: rd_val = s_q.pper;
      ppg_pkg::OFS_TCMP: rd_val = s_q.tcmp;
      default: rd_val = ppg_pkg::PAD_ZERO;
    endcase
  end

  // ***************************************************************
  // Time bases
  // ***************************************************************
  assign restart = s_q.ctrl.limit_resets_timebase & s_q.ctrl.own_timebase_select & LIMIT_IN;
  // Own period drops the four lowest phase bits, shared mode loads phase as an offset
  assign gen_period = s_q.ctrl.own_timebase_select ? (s_q.phase & ppg_pkg::ITB_PERIOD_MASK) : s_q.pper;
  assign gen_load = restart | (~s_q.ctrl.own_timebase_select & prim_wrap);
  assign gen_load_val = restart ? ppg_pkg::PAD_ZERO : s_q.phase;

  ppg_timebase u_prim_tb (
    .clk(CORE_CLK),
    .nrst(NRST),
    .period(s_q.pper),
    .load(1'b0),
    .load_val(ppg_pkg::PAD_ZERO),
    .cnt(prim_cnt),
    .wrap(prim_wrap)
  );
  ppg_timebase u_gen_tb (
    .clk(CORE_CLK),
    .nrst(NRST),
    .period(gen_period),
    .load(gen_load),
    .load_val(gen_load_val),
    .cnt(gen_cnt),
    .wrap(gen_wrap)
  );

  // ***************************************************************
  // Waveform, pair mode and dead time
  // ***************************************************************
  assign sel_duty = s_q.ctrl.shared_duty_select ? s_q.mduty : s_q.act_duty;
  assign raw = gen_cnt < sel_duty;
  assign trig_evt = (s_q.tcmp != ppg_pkg::TRG_NONE) & (gen_cnt == s_q.tcmp);

  always_comb begin
    unique case (s_q.io.pin_pair_mode)
      ppg_pkg::PM_COMP: begin
        gh = raw;
        gl = ~raw;
      end
      ppg_pkg::PM_INDEP: begin
        gh = raw;
        gl = raw;
      end
      ppg_pkg::PM_PUSH: begin
        gh = raw & s_q.push_sel;
        gl = raw & ~s_q.push_sel;
      end
      ppg_pkg::PM_RSV: begin
        gh = 1'b0;
        gl = 1'b0;
      end
    endcase
  end

  // Delayed edges use the primary value on the high side, the alternate on the low side
  ppg_deadband u_db_h (
    .clk(CORE_CLK),
    .nrst(NRST),
    .mode(s_q.ctrl.deadtime_mode),
    .delay(s_q.dt.val),
    .in_lvl(gh),
    .out_lvl(db_h)
  );
  ppg_deadband u_db_l (
    .clk(CORE_CLK),
    .nrst(NRST),
    .mode(s_q.ctrl.deadtime_mode),
    .delay(s_q.altdt.val),
    .in_lvl(gl),
    .out_lvl(db_l)
  );

  // ***************************************************************
  // Output steering
  // ***************************************************************
  always_comb begin
    pin_h = db_h;
    pin_l = db_l;
    if (s_q.frc_en.h) begin
      pin_h = s_q.frc_val.h;
    end
    if (s_q.frc_en.l) begin
      pin_l = s_q.frc_val.l;
    end
    if (LIMIT_IN) begin
      pin_h = s_q.io.limit_pin_values.h;
      pin_l = s_q.io.limit_pin_values.l;
    end
    if (FAULT_IN) begin
      pin_h = s_q.io.fault_pin_values.h;
      pin_l = s_q.io.fault_pin_values.l;
    end
    pin_h = s_q.io.high_pin_owner ? (pin_h ^ s_q.io.high_pin_invert) : GPIO_HIGH;
    pin_l = s_q.io.low_pin_owner ? (pin_l ^ s_q.io.low_pin_invert) : GPIO_LOW;
  end

  // ***************************************************************
  // Next state
  // ***************************************************************
  always_comb begin
    s_d = s_q;
    s_d.lim_prev = LIMIT_IN;
    s_d.flt_prev = FAULT_IN;
    s_d.waitreq = 1'b1;
    if (req && s_q.waitreq) begin
      s_d.waitreq = 1'b0;
      s_d.rdata = AVS_READ ? rd_val : s_q.rdata;
    end
    if (wr_acc) begin
      case (AVS_ADDRESS)
        ppg_pkg::OFS_CTRL: s_d.ctrl = (wval & ppg_pkg::CTRL_WR_MASK) | (s_q.ctrl & ppg_pkg::CTRL_STAT_MASK);
        ppg_pkg::OFS_DUTY: begin
          s_d.duty = wval;
          if (s_q.ctrl.duty_update_now) begin
            s_d.act_duty = wval;
          end
        end
        ppg_pkg::OFS_PHASE: s_d.phase = wval & ppg_pkg::PHASE_MASK;
        ppg_pkg::OFS_DT: s_d.dt = wval & ppg_pkg::DT_MASK;
        ppg_pkg::OFS_ALTDT: s_d.altdt = wval & ppg_pkg::DT_MASK;
        ppg_pkg::OFS_TRG: begin
          s_d.trg = wval & ppg_pkg::TRG_MASK;
          s_d.armed = 1'b0;
          s_d.div = '0;
        end
        ppg_pkg::OFS_IO: s_d.io = wval & ppg_pkg::IO_MASK;
        ppg_pkg::OFS_MDUTY: s_d.mduty = wval;
        ppg_pkg::OFS_PPER: s_d.pper = wval;
        ppg_pkg::OFS_TCMP: s_d.tcmp = wval;
        default: ;
      endcase
    end
    // Buffered duty only moves at the period edge so a cycle never sees a torn value
    if (gen_wrap && !s_q.ctrl.duty_update_now) begin
      s_d.act_duty = s_q.duty;
    end
    if (gen_wrap) begin
      s_d.push_sel = ~s_q.push_sel;
      s_d.roll = 6'(s_q.roll + 6'h01);
    end
    if (s_q.roll == s_q.trg.postscale_start_count) begin
      s_d.armed = 1'b1;
    end
    s_d.adc_trig = 1'b0;
    if (trig_evt && s_q.armed) begin
      if (s_q.div >= s_q.trg.trigger_divider) begin
        s_d.div = '0;
        s_d.adc_trig = 1'b1;
      end else begin
        s_d.div = 3'(s_q.div + 3'h1);
      end
    end
    // Enable low clears the flag; a new event with enable high sets it
    s_d.ctrl.trigger_irq_pending = s_d.ctrl.trigger_irq_enable & (s_d.ctrl.trigger_irq_pending | s_d.adc_trig);
    s_d.ctrl.limit_irq_pending = s_d.ctrl.limit_irq_enable &
      (s_d.ctrl.limit_irq_pending | (LIMIT_IN & ~s_q.lim_prev));
    s_d.ctrl.fault_irq_pending = s_d.ctrl.fault_irq_enable &
      (s_d.ctrl.fault_irq_pending | (FAULT_IN & ~s_q.flt_prev));
    if (!s_q.io.force_sync_to_period || gen_wrap) begin
      s_d.frc_en = {s_q.io.high_force_enable, s_q.io.low_force_enable};
      s_d.frc_val = s_q.io.forced_pin_values;
    end
    s_d.out_h = pin_h;
    s_d.out_l = pin_l;
  end

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      s_q <= '0;
      s_q.waitreq <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign AVS_READDATA = {ppg_pkg::PAD_ZERO, s_q.rdata};
  assign AVS_WAITREQUEST = s_q.waitreq;
  assign HIGH_SIDE_OUT = s_q.out_h;
  assign LOW_SIDE_OUT = s_q.out_l;
  assign ADC_TRIGGER = s_q.adc_trig;
  assign FAULT_IRQ = s_q.ctrl.fault_irq_pending;
  assign LIMIT_IRQ = s_q.ctrl.limit_irq_pending;
  assign TRIGGER_IRQ = s_q.ctrl.trigger_irq_pending;

  // ***************************************************************
  // Assertions
  // ***************************************************************
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!NRST);

  property p_lim_clear;
    !s_q.ctrl.limit_irq_enable |-> !LIMIT_IRQ;
  endproperty
  a_lim_clear: assert property (p_lim_clear) else $error("limit flag set while disabled");
  property p_trg_irq;
    ADC_TRIGGER && s_q.ctrl.trigger_irq_enable |-> TRIGGER_IRQ;
  endproperty
  a_trg_irq: assert property (p_trg_irq) else $error("trigger event without request");
  property p_own_wrap;
    s_q.ctrl.own_timebase_select && gen_wrap && !restart |=> gen_cnt == ppg_pkg::PAD_ZERO;
  endproperty
  a_own_wrap: assert property (p_own_wrap) else $error("own time base did not wrap");
  property p_shared_duty;
    s_q.ctrl.shared_duty_select |-> raw == (gen_cnt < s_q.mduty);
  endproperty
  a_shared_duty: assert property (p_shared_duty) else $error("master duty not used");
  property p_limit_restart;
    restart |=> gen_cnt == ppg_pkg::PAD_ZERO;
  endproperty
  a_limit_restart: assert property (p_limit_restart) else $error("limit did not restart time base");
  property p_duty_hold;
    !s_q.ctrl.duty_update_now && !gen_wrap |=> $stable(s_q.act_duty);
  endproperty
  a_duty_hold: assert property (p_duty_hold) else $error("duty changed off boundary");
  property p_unarmed;
    !s_q.armed ##1 !s_q.armed |-> !ADC_TRIGGER;
  endproperty
  a_unarmed: assert property (p_unarmed) else $error("trigger before postscaler start");
  property p_fault_pins;
    FAULT_IN && s_q.io.high_pin_owner |=>
      HIGH_SIDE_OUT == ($past(s_q.io.fault_pin_values.h) ^ $past(s_q.io.high_pin_invert));
  endproperty
  a_fault_pins: assert property (p_fault_pins) else $error("fault data not on high pin");
  property p_trg_rsv;
    AVS_READ && !AVS_WAITREQUEST && $past(AVS_ADDRESS) == ppg_pkg::OFS_TRG |-> AVS_READDATA[12:6] == 7'h00;
  endproperty
  a_trg_rsv: assert property (p_trg_rsv) else $error("trigger reserved bits not zero");
  property p_zero_cmp;
    s_q.tcmp == ppg_pkg::TRG_NONE |=> !ADC_TRIGGER;
  endproperty
  a_zero_cmp: assert property (p_zero_cmp) else $error("trigger with zero compare");
  c_trigger: cover property (ADC_TRIGGER ##1 !ADC_TRIGGER);
  c_write: cover property (AVS_WRITE && !AVS_WAITREQUEST);
  c_fault: cover property (FAULT_IN [*3]);
  c_reload: cover property (gen_wrap && !s_q.ctrl.duty_update_now && s_q.duty != s_q.act_duty);

endmodule

// File: ppg_pkg.sv
// Shared constants, register layouts and modes of the PWM generator control block
package ppg_pkg;

  // ***************************************************************
  // Register map (byte addresses on the Avalon-MM slave)
  // ***************************************************************
  localparam int ADDR_W = 6;
  localparam logic [5:0] OFS_CTRL = 6'h00;
  localparam logic [5:0] OFS_DUTY = 6'h04;
  localparam logic [5:0] OFS_PHASE = 6'h08;
  localparam logic [5:0] OFS_DT = 6'h0c;
  localparam logic [5:0] OFS_ALTDT = 6'h10;
  localparam logic [5:0] OFS_TRG = 6'h14;
  localparam logic [5:0] OFS_IO = 6'h18;
  localparam logic [5:0] OFS_MDUTY = 6'h1c;
  localparam logic [5:0] OFS_PPER = 6'h20;
  localparam logic [5:0] OFS_TCMP = 6'h24;

  // ***************************************************************
  // Writable and status bit masks, reserved bits read as zero
  // ***************************************************************
  localparam logic [15:0] CTRL_WR_MASK = 16'h1fc3;
  localparam logic [15:0] CTRL_STAT_MASK = 16'he000;
  localparam logic [15:0] PHASE_MASK = 16'hfffc;
  localparam logic [15:0] ITB_PERIOD_MASK = 16'hfff0;
  localparam logic [15:0] DT_MASK = 16'h3ffc;
  localparam logic [15:0] TRG_MASK = 16'he03f;
  localparam logic [15:0] IO_MASK = 16'hfffd;
  localparam logic [15:0] PAD_ZERO = 16'h0000;
  localparam logic [15:0] TRG_NONE = 16'h0000;
  localparam logic [15:0] CNT_ONE = 16'h0001;

  // ***************************************************************
  // Modes
  // ***************************************************************
  typedef enum logic [1:0] {DT_POS = 2'h0, DT_NEG = 2'h1, DT_OFF = 2'h2, DT_RSV = 2'h3} ppg_dt_e_t;
  typedef enum logic [1:0] {PM_COMP = 2'h0, PM_INDEP = 2'h1, PM_PUSH = 2'h2, PM_RSV = 2'h3} ppg_pair_e_t;

  // ***************************************************************
  // Register layouts
  // ***************************************************************
  typedef struct packed {
    logic h;
    logic l;
  } ppg_pins_t;

  typedef struct packed {
    logic fault_irq_pending;
    logic limit_irq_pending;
    logic trigger_irq_pending;
    logic fault_irq_enable;
    logic limit_irq_enable;
    logic trigger_irq_enable;
    logic own_timebase_select;
    logic shared_duty_select;
    ppg_dt_e_t deadtime_mode;
    logic [3:0] rsv;
    logic limit_resets_timebase;
    logic duty_update_now;
  } ppg_ctrl_t;

  typedef struct packed {
    logic [1:0] rsv_hi;
    logic [11:0] val;
    logic [1:0] rsv_lo;
  } ppg_dtreg_t;

  typedef struct packed {
    logic [2:0] trigger_divider;
    logic [6:0] rsv;
    logic [5:0] postscale_start_count;
  } ppg_trg_t;

  typedef struct packed {
    logic high_pin_owner;
    logic low_pin_owner;
    logic high_pin_invert;
    logic low_pin_invert;
    ppg_pair_e_t pin_pair_mode;
    logic high_force_enable;
    logic low_force_enable;
    ppg_pins_t forced_pin_values;
    ppg_pins_t fault_pin_values;
    ppg_pins_t limit_pin_values;
    logic rsv;
    logic force_sync_to_period;
  } ppg_io_t;

endpackage

// File: ppg_stage_model.sv
// Far-side model: power stage switch inputs and the ADC trigger input
`timescale 1ns/1ps
module ppg_stage_model (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // From the generator
  input wire logic high_side_out,
  input wire logic low_side_out,
  input wire logic adc_trigger,
  // Measurements
  output int pulses,
  output int gap
);
  int since;

  // ***************************************************************
  // Trigger input: one conversion per cycle high, spacing kept
  // ***************************************************************
  // Spacing is counted in cycles, so a pulse stretched to two cycles shows up as a gap of one
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pulses <= 0;
      gap <= 0;
      since <= 0;
    end else if (adc_trigger === 1'b1) begin
      pulses <= pulses + 1;
      gap <= since + 1;
      since <= 0;
    end else begin
      since <= since + 1;
    end
  end
endmodule

// File: ppg_timebase.sv
// Free-running period counter with load, used for shared and own time base
`timescale 1ns/1ps
module ppg_timebase (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Control
  input wire logic [15:0] period,
  input wire logic load,
  input wire logic [15:0] load_val,
  // Count
  output logic [15:0] cnt,
  output logic wrap
);

  typedef struct packed {
    logic [15:0] cnt;
  } ppg_tb_state_t;

  ppg_tb_state_t s_q, s_d;

  assign cnt = s_q.cnt;
  assign wrap = (s_q.cnt >= period) & ~load;

  always_comb begin
    s_d = s_q;
    if (load) begin
      s_d.cnt = load_val;
    end else if (s_q.cnt >= period) begin
      s_d.cnt = '0;
    end else begin
      s_d.cnt = 16'(s_q.cnt + ppg_pkg::CNT_ONE);
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule

// File: testbench.sv
// Self-checking bench for the PWM generator control block
`timescale 1ns/1ps
module testbench;
  // ***************************************************************
  // Signals
  // ***************************************************************
  logic CORE_CLK = 1'b0;
  logic NRST = 1'b0;
  logic [5:0] AVS_ADDRESS = 6'h00;
  logic AVS_READ = 1'b0;
  logic AVS_WRITE = 1'b0;
  logic [31:0] AVS_WRITEDATA = 32'h00000000;
  logic [3:0] AVS_BYTEENABLE = 4'hf;
  logic [31:0] AVS_READDATA;
  logic AVS_WAITREQUEST;
  logic FAULT_IN = 1'b0;
  logic LIMIT_IN = 1'b0;
  logic GPIO_HIGH = 1'b0;
  logic GPIO_LOW = 1'b0;
  logic HIGH_SIDE_OUT, LOW_SIDE_OUT, ADC_TRIGGER, FAULT_IRQ, LIMIT_IRQ, TRIGGER_IRQ;
  int mismatches = 0;
  int compares = 0;
  int seed = 45011;
  int pulses;
  int gap;
  logic [15:0] rd_q[$];
  logic [4:0] pin_q[$];
  event pin_ev;
  localparam logic [5:0] OFS_LIST [8] = '{ppg_pkg::OFS_CTRL, ppg_pkg::OFS_DUTY, ppg_pkg::OFS_PHASE,
    ppg_pkg::OFS_DT, ppg_pkg::OFS_ALTDT, ppg_pkg::OFS_TRG, ppg_pkg::OFS_IO, 6'h3c};
  localparam logic [15:0] MASKS [8] = '{ppg_pkg::CTRL_WR_MASK, 16'hffff, ppg_pkg::PHASE_MASK,
    ppg_pkg::DT_MASK, ppg_pkg::DT_MASK, ppg_pkg::TRG_MASK, ppg_pkg::IO_MASK, ppg_pkg::PAD_ZERO};

  always #10 CORE_CLK = ~CORE_CLK;

  ppg_generator u_ppg_generator (.CORE_CLK(CORE_CLK), .NRST(NRST), .AVS_ADDRESS(AVS_ADDRESS),
    .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
    .AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
    .FAULT_IN(FAULT_IN), .LIMIT_IN(LIMIT_IN), .GPIO_HIGH(GPIO_HIGH), .GPIO_LOW(GPIO_LOW),
    .HIGH_SIDE_OUT(HIGH_SIDE_OUT), .LOW_SIDE_OUT(LOW_SIDE_OUT), .ADC_TRIGGER(ADC_TRIGGER),
    .FAULT_IRQ(FAULT_IRQ), .LIMIT_IRQ(LIMIT_IRQ), .TRIGGER_IRQ(TRIGGER_IRQ));

  ppg_stage_model u_ppg_stage_model (.clk(CORE_CLK), .nrst(NRST), .high_side_out(HIGH_SIDE_OUT),
    .low_side_out(LOW_SIDE_OUT), .adc_trigger(ADC_TRIGGER), .pulses(pulses), .gap(gap));

  // ***************************************************************
  // Compare, bus cycles and expected pins
  // ***************************************************************
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Request held until waitrequest is sampled low; a hang is left to the watchdog
  task automatic bus(input logic we, input logic [5:0] a, input logic [15:0] d);
    @(posedge CORE_CLK);
    AVS_ADDRESS <= a;
    AVS_WRITE <= we;
    AVS_READ <= ~we;
    AVS_WRITEDATA <= {16'h0000, d};
    do begin
      @(posedge CORE_CLK);
    end while (AVS_WAITREQUEST !== 1'b0);
    AVS_WRITE <= 1'b0;
    AVS_READ <= 1'b0;
  endtask

  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [5:0] a, input logic [15:0] exp);
    rd_q.push_back(exp);
    bus(1'b0, a, 16'h0000);
  endtask

  task automatic pins(input logic [4:0] exp);
    pin_q.push_back(exp);
    -> pin_ev;
  endtask

  function automatic logic [1:0] exp_pins(input logic [15:0] io, input logic fi, li, gh, gl);
    logic h;
    logic l;
    h = fi ? io[5] : (li ? io[3] : io[7]);
    l = fi ? io[4] : (li ? io[2] : io[6]);
    h = io[15] ? h ^ io[13] : gh;
    l = io[14] ? l ^ io[12] : gl;
    return {h, l};
  endfunction

  // ***************************************************************
  // Result watchers: oldest note against what appears
  // ***************************************************************
  always @(posedge CORE_CLK) begin
    if (AVS_READ === 1'b1 && AVS_WAITREQUEST === 1'b0) begin
      if (rd_q.size() == 0) mismatches++;
      else chk("read data", AVS_READDATA[15:0], rd_q.pop_front());
    end
  end

  always @(pin_ev) begin
    chk("pins and flags", {11'h000, HIGH_SIDE_OUT, LOW_SIDE_OUT, FAULT_IRQ, LIMIT_IRQ, TRIGGER_IRQ},
      {11'h000, pin_q.pop_front()});
  end

  // ***************************************************************
  // Main sequence
  // ***************************************************************
  initial begin
    logic [15:0] d;
    logic [15:0] io;
    logic fs;
    logic ls;
    int c0;
    int base;
    repeat (8) @(posedge CORE_CLK);
    NRST <= 1'b1;
    @(posedge CORE_CLK);
    for (int i = 0; i < 8; i++) begin
      rd(OFS_LIST[i], 16'h0000);
      d = 16'($random(seed));
      if (i == 1) d = (d & 16'h7fff) | 16'h0008;
      wr(OFS_LIST[i], d);
      rd(OFS_LIST[i], d & MASKS[i]);
    end
    wr(ppg_pkg::OFS_DUTY, 16'hffef);
    rd(ppg_pkg::OFS_DUTY, 16'hffef);
    wr(ppg_pkg::OFS_TCMP, 16'h0000);
    wr(ppg_pkg::OFS_CTRL, 16'h1c80);
    fs = 1'b0;
    ls = 1'b0;
    for (int i = 0; i < 12; i++) begin
      d = 16'($random(seed));
      io = {d[1:0], d[3:2], 2'b00, 2'b11, d[5:4], d[7:6], d[9:8], 2'b00};
      wr(ppg_pkg::OFS_IO, io);
      @(posedge CORE_CLK);
      fs = fs | (d[10] & ~FAULT_IN);
      ls = ls | (d[11] & ~LIMIT_IN);
      FAULT_IN <= d[10];
      LIMIT_IN <= d[11];
      GPIO_HIGH <= d[12];
      GPIO_LOW <= d[13];
      repeat (4) @(posedge CORE_CLK);
      pins({exp_pins(io, d[10], d[11], d[12], d[13]), fs, ls, 1'b0});
    end
    rd(ppg_pkg::OFS_CTRL, {fs, ls, 14'h1c80});
    FAULT_IN <= 1'b0;
    LIMIT_IN <= 1'b0;
    wr(ppg_pkg::OFS_CTRL, 16'h0080);
    rd(ppg_pkg::OFS_CTRL, 16'h0080);
    FAULT_IN <= 1'b1;
    repeat (4) @(posedge CORE_CLK);
    pins({exp_pins(io, 1'b1, 1'b0, d[12], d[13]), 3'b000});
    FAULT_IN <= 1'b0;
    wr(ppg_pkg::OFS_IO, 16'h0000);
    wr(ppg_pkg::OFS_PHASE, 16'h0048);
    wr(ppg_pkg::OFS_TCMP, 16'h0010);
    wr(ppg_pkg::OFS_CTRL, 16'h0680);
    // Own period counts from zero up to the masked phase value inclusive
    base = int'(16'h0048 & ppg_pkg::ITB_PERIOD_MASK) + 1;
    for (int n = 0; n < 8; n++) begin
      wr(ppg_pkg::OFS_TRG, {n[2:0], 13'h0000});
      c0 = pulses;
      while (pulses < c0 + 3) begin
        @(posedge CORE_CLK);
      end
      chk("trigger spacing", 16'(gap), 16'(base * (n + 1)));
    end
    pins({d[12], d[13], 3'b001});
    rd(ppg_pkg::OFS_CTRL, 16'h2680);
    wr(ppg_pkg::OFS_CTRL, 16'h0280);
    rd(ppg_pkg::OFS_CTRL, 16'h0280);
    pins({d[12], d[13], 3'b000});
    // A held limit keeps the own count at zero, so the compare is never met
    wr(ppg_pkg::OFS_CTRL, 16'h0282);
    LIMIT_IN <= 1'b1;
    repeat (2) @(posedge CORE_CLK);
    c0 = pulses;
    repeat (600) @(posedge CORE_CLK);
    chk("restart count", 16'(pulses - c0), 16'h0000);
    LIMIT_IN <= 1'b0;
    wr(ppg_pkg::OFS_TCMP, 16'h0000);
    repeat (2) @(posedge CORE_CLK);
    c0 = pulses;
    // Divider is still seven, so the window spans more than eight periods
    repeat (600) @(posedge CORE_CLK);
    chk("trigger count", 16'(pulses - c0), 16'h0000);
    close_out();
  end

  // ***************************************************************
  // Verdict and watchdog
  // ***************************************************************
  task automatic close_out();
    $display("Comparisons %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Longest path is the trigger sweep, eight steps of at most 9000 cycles
  initial begin
    #1_800_000;
    mismatches++;
    close_out();
  end
endmodule
